//--- core/hao_homing_objects.sv
// Purpose: homing sequencer and offset object store
// Assumes: inputs synchronous to clk_in, object port driven by host side
// Notes: homing speeds are magnitudes; direction is chosen elsewhere
`timescale 1ns/100ps
module hao_homing_objects #(
  parameter int TICK_CYCLES = hao_pkg::CTRL_TICK_CYCLES,
  parameter int TIMEOUT_TICKS = hao_pkg::HOMING_TIMEOUT_TICKS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire hao_pkg::hao_obj_req_t obj_req_in,
  output hao_pkg::hao_obj_rsp_t obj_rsp_out,
  input wire hao_pkg::hao_mode_t mode_in,
  input wire logic homing_start_in,
  input wire logic halt_in,
  input wire logic [15:0] stop_option_setting_in,
  input wire logic decel_point_in,
  input wire logic home_signal_in,
  input wire logic [31:0] commanded_target_position_in,
  input wire logic [31:0] speed_ref_in,
  input wire logic [15:0] commanded_target_torque_in,
  input wire logic [15:0] speed_feedforward_source_setting_in,
  input wire logic [15:0] torque_feedforward_source_setting_in,
  output logic [31:0] homing_speed_out,
  output logic [31:0] homing_accel_out,
  output logic homing_busy_out,
  output logic homing_done_out,
  output logic homing_timeout_fault_out,
  output logic home_blocked_out,
  output hao_pkg::hao_probe_cfg_t probe1_cfg_out,
  output hao_pkg::hao_probe_cfg_t probe2_cfg_out,
  output logic [31:0] eff_target_position_out,
  output logic [31:0] eff_speed_ref_out,
  output logic [31:0] speed_ff_out,
  output logic [15:0] torque_ff_out,
  output logic [15:0] eff_target_torque_out
);

  // ----------------------------------------------------------------
  // object store
  // ----------------------------------------------------------------
  hao_pkg::hao_objs_t objs_r;
  hao_pkg::hao_objs_t objs_nxt;
  hao_pkg::hao_obj_rsp_t rsp_nxt;
  hao_pkg::hao_probe_cfg_t prb1_nxt;
  hao_pkg::hao_probe_cfg_t prb2_nxt;

  always_comb
  begin
    objs_nxt = objs_r;
    rsp_nxt = '0;
    if (obj_req_in.wr)
    begin
      rsp_nxt.ack = 1'b1;
      unique case (obj_req_in.index)
        hao_pkg::IDX_HOME_SPEED:
        begin
          if (obj_req_in.sub == hao_pkg::SUB_SWITCH)
            objs_nxt.sw_speed = obj_req_in.wdata;
          else if (obj_req_in.sub == hao_pkg::SUB_ZERO &&
                   obj_req_in.wdata >= hao_pkg::ZERO_SPEED_MIN)
            objs_nxt.zero_speed = obj_req_in.wdata;
          else
            rsp_nxt.err = 1'b1;
        end
        hao_pkg::IDX_HOME_ACC:
        begin
          if (obj_req_in.wdata == 32'h0)
            objs_nxt.acc = hao_pkg::ACC_ZERO_SUBST;
          else
            objs_nxt.acc = obj_req_in.wdata;
        end
        hao_pkg::IDX_POS_OFF:
          objs_nxt.pos_off = obj_req_in.wdata;
        hao_pkg::IDX_VEL_OFF:
          objs_nxt.vel_off = obj_req_in.wdata;
        hao_pkg::IDX_TRQ_OFF:
        begin
          // out-of-range torque offsets are refused, old value kept
          if ($signed(obj_req_in.wdata) > 32'(hao_pkg::TRQ_OFF_MAX) ||
              $signed(obj_req_in.wdata) < 32'(hao_pkg::TRQ_OFF_MIN))
            rsp_nxt.err = 1'b1;
          else
            objs_nxt.trq_off = obj_req_in.wdata[15:0];
        end
        hao_pkg::IDX_PROBE_FN:
          objs_nxt.probe_fn = obj_req_in.wdata[15:0];
        default:
          rsp_nxt.err = 1'b1;
      endcase
    end
    else if (obj_req_in.rd)
    begin
      rsp_nxt.ack = 1'b1;
      unique case (obj_req_in.index)
        hao_pkg::IDX_HOME_SPEED:
        begin
          if (obj_req_in.sub == hao_pkg::SUB_COUNT)
            rsp_nxt.rdata = {24'h0, hao_pkg::HOME_SPEED_ENTRIES};
          else if (obj_req_in.sub == hao_pkg::SUB_SWITCH)
            rsp_nxt.rdata = objs_r.sw_speed;
          else if (obj_req_in.sub == hao_pkg::SUB_ZERO)
            rsp_nxt.rdata = objs_r.zero_speed;
          else
            rsp_nxt.err = 1'b1;
        end
        hao_pkg::IDX_HOME_ACC:
          rsp_nxt.rdata = objs_r.acc;
        hao_pkg::IDX_POS_OFF:
          rsp_nxt.rdata = objs_r.pos_off;
        hao_pkg::IDX_VEL_OFF:
          rsp_nxt.rdata = objs_r.vel_off;
        hao_pkg::IDX_TRQ_OFF:
          rsp_nxt.rdata = 32'($signed(objs_r.trq_off));
        hao_pkg::IDX_PROBE_FN:
          rsp_nxt.rdata = {16'h0, objs_r.probe_fn};
        default:
          rsp_nxt.err = 1'b1;
      endcase
    end
    // src_index selects the encoder index, i.e. each revolution's zero
    prb1_nxt = hao_pkg::hao_probe_cfg(
      objs_nxt.probe_fn[hao_pkg::PRB1_BASE +: 6]);
    prb2_nxt = hao_pkg::hao_probe_cfg(
      objs_nxt.probe_fn[hao_pkg::PRB2_BASE +: 6]);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      objs_r.sw_speed <= hao_pkg::SW_SPEED_RST;
      objs_r.zero_speed <= hao_pkg::ZERO_SPEED_RST;
      objs_r.acc <= hao_pkg::ACC_RST;
      objs_r.pos_off <= hao_pkg::OFFSET32_RST;
      objs_r.vel_off <= hao_pkg::OFFSET32_RST;
      objs_r.trq_off <= hao_pkg::OFFSET16_RST;
      objs_r.probe_fn <= hao_pkg::PROBE_FN_RST;
      obj_rsp_out <= '0;
      probe1_cfg_out <= '0;
      probe2_cfg_out <= '0;
    end
    else
    begin
      objs_r <= objs_nxt;
      obj_rsp_out <= rsp_nxt;
      probe1_cfg_out <= prb1_nxt;
      probe2_cfg_out <= prb2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // control tick
  // ----------------------------------------------------------------
  logic tick;

  hao_tick #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // ----------------------------------------------------------------
  // homing sequencer
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    HS_IDLE = 7'b0000001,
    HS_SWITCH = 7'b0000010,
    HS_DECEL = 7'b0000100,
    HS_ZERO = 7'b0001000,
    HS_DONE = 7'b0010000,
    HS_FAULT = 7'b0100000,
    HS_STOP = 7'b1000000
  } hao_home_state_t;

  hao_home_state_t hs_r;
  hao_home_state_t hs_nxt;
  logic [31:0] speed_r;
  logic [31:0] speed_nxt;
  logic [31:0] acc_run_r;
  logic [31:0] acc_run_nxt;
  logic [31:0] tmo_r;
  logic [31:0] tmo_nxt;
  logic home_prev_r;
  logic fault_r;
  logic fault_nxt;
  logic [31:0] step;
  logic home_rise;
  logic searching;

  always_comb
  begin
    hs_nxt = hs_r;
    speed_nxt = speed_r;
    acc_run_nxt = acc_run_r;
    tmo_nxt = tmo_r;
    fault_nxt = fault_r;
    step = hao_pkg::hao_ramp_step(acc_run_r);
    home_rise = home_signal_in & ~home_prev_r;
    searching = (hs_r == HS_SWITCH) || (hs_r == HS_DECEL) ||
                (hs_r == HS_ZERO);
    if (searching && tick)
      tmo_nxt = tmo_r + 32'h1;
    // other stop options stop at once; a drive-level ramp applies there
    if (halt_in && (searching || hs_r == HS_STOP) &&
        stop_option_setting_in != hao_pkg::STOP_OPT_HOMING_ACC)
    begin
      hs_nxt = HS_IDLE;
      speed_nxt = 32'h0;
    end
    // a held halt must not re-take the stop state, or the ramp would stall
    else if (halt_in && searching)
      hs_nxt = HS_STOP;
    else if (homing_start_in && mode_in == hao_pkg::MODE_HOMING &&
             !searching && hs_r != HS_STOP)
    begin
      hs_nxt = HS_SWITCH;
      acc_run_nxt = objs_r.acc;
      speed_nxt = objs_r.sw_speed;
      tmo_nxt = 32'h0;
      fault_nxt = 1'b0;
    end
    else if (searching && tmo_r >= 32'(TIMEOUT_TICKS))
    begin
      hs_nxt = HS_FAULT;
      fault_nxt = 1'b1;
      speed_nxt = 32'h0;
    end
    else
    begin
      unique case (hs_r)
        HS_IDLE, HS_DONE, HS_FAULT:
          speed_nxt = 32'h0;
        HS_SWITCH:
        begin
          speed_nxt = objs_r.sw_speed;
          if (decel_point_in)
            hs_nxt = HS_DECEL;
        end
        HS_DECEL:
        begin
          // home edges here are dropped until zero-search speed is reached
          if (speed_r <= objs_r.zero_speed ||
              speed_r - objs_r.zero_speed <= step)
          begin
            if (tick)
            begin
              speed_nxt = objs_r.zero_speed;
              hs_nxt = HS_ZERO;
            end
          end
          else if (tick)
            speed_nxt = speed_r - step;
        end
        HS_ZERO:
        begin
          speed_nxt = objs_r.zero_speed;
          if (home_rise)
          begin
            hs_nxt = HS_DONE;
            speed_nxt = 32'h0;
          end
        end
        HS_STOP:
        begin
          if (tick)
          begin
            if (speed_r <= step)
            begin
              speed_nxt = 32'h0;
              hs_nxt = HS_IDLE;
            end
            else
              speed_nxt = speed_r - step;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hs_r <= HS_IDLE;
      speed_r <= 32'h0;
      acc_run_r <= hao_pkg::ACC_RST;
      tmo_r <= 32'h0;
      home_prev_r <= 1'b0;
      fault_r <= 1'b0;
      homing_speed_out <= 32'h0;
      homing_accel_out <= hao_pkg::ACC_RST;
      homing_busy_out <= 1'b0;
      homing_done_out <= 1'b0;
      homing_timeout_fault_out <= 1'b0;
      home_blocked_out <= 1'b0;
    end
    else
    begin
      hs_r <= hs_nxt;
      speed_r <= speed_nxt;
      acc_run_r <= acc_run_nxt;
      tmo_r <= tmo_nxt;
      home_prev_r <= home_signal_in;
      fault_r <= fault_nxt;
      homing_speed_out <= speed_nxt;
      homing_accel_out <= acc_run_nxt;
      homing_busy_out <= (hs_nxt == HS_SWITCH) || (hs_nxt == HS_DECEL) ||
                         (hs_nxt == HS_ZERO) || (hs_nxt == HS_STOP);
      homing_done_out <= (hs_nxt == HS_DONE);
      homing_timeout_fault_out <= fault_nxt;
      home_blocked_out <= (hs_nxt == HS_DECEL);
    end
  end

  // ----------------------------------------------------------------
  // cyclic reference offsets
  // ----------------------------------------------------------------
  hao_ref_sum u_ref_sum (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .mode_in(mode_in),
    .objs_in(objs_r),
    .commanded_target_position_in(commanded_target_position_in),
    .speed_ref_in(speed_ref_in),
    .commanded_target_torque_in(commanded_target_torque_in),
    .speed_feedforward_source_setting_in(
      speed_feedforward_source_setting_in),
    .torque_feedforward_source_setting_in(
      torque_feedforward_source_setting_in),
    .eff_target_position_out(eff_target_position_out),
    .eff_speed_ref_out(eff_speed_ref_out),
    .speed_ff_out(speed_ff_out),
    .torque_ff_out(torque_ff_out),
    .eff_target_torque_out(eff_target_torque_out)
  );

endmodule

//--- core/hao_pkg.sv
// Purpose: shared constants and types of the homing and offset objects
// Assumes: one 200 MHz clock, one control tick every 125 us
// Notes: object indices and sub-indices are the dictionary addresses
package hao_pkg;

  // ----------------------------------------------------------------
  // object addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_HOME_SPEED = 16'h6099;
  localparam logic [15:0] IDX_HOME_ACC = 16'h609A;
  localparam logic [15:0] IDX_POS_OFF = 16'h60B0;
  localparam logic [15:0] IDX_VEL_OFF = 16'h60B1;
  localparam logic [15:0] IDX_TRQ_OFF = 16'h60B2;
  localparam logic [15:0] IDX_PROBE_FN = 16'h60B8;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_SWITCH = 8'h01;
  localparam logic [7:0] SUB_ZERO = 8'h02;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] HOME_SPEED_ENTRIES = 8'h02;
  localparam logic [31:0] SW_SPEED_RST = 32'h001AAAAB;
  localparam logic [31:0] ZERO_SPEED_RST = 32'h00000064;
  localparam logic [31:0] ZERO_SPEED_MIN = 32'h0000000A;
  localparam logic [31:0] ACC_RST = 32'h00000064;
  localparam logic [31:0] ACC_ZERO_SUBST = 32'h00000001;
  localparam logic [31:0] OFFSET32_RST = 32'h00000000;
  localparam logic [15:0] OFFSET16_RST = 16'h0000;
  localparam logic [15:0] PROBE_FN_RST = 16'h0000;
  localparam logic signed [15:0] TRQ_OFF_MAX = 16'sh0BB8;
  localparam logic signed [15:0] TRQ_OFF_MIN = -16'sh0BB8;
  localparam logic signed [15:0] TRQ_SAT_MAX = 16'sh7FFF;
  localparam logic signed [15:0] TRQ_SAT_MIN = -16'sh8000;
  localparam logic [15:0] FF_SRC_EXTERNAL = 16'h0002;
  localparam logic [15:0] STOP_OPT_HOMING_ACC = 16'h0002;

  // ----------------------------------------------------------------
  // probe function word layout
  // ----------------------------------------------------------------
  localparam int PRB1_BASE = 0;
  localparam int PRB2_BASE = 8;
  localparam int PRB_EN = 0;
  localparam int PRB_CONT = 1;
  localparam int PRB_SRC = 2;
  localparam int PRB_POS = 4;
  localparam int PRB_NEG = 5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int CTRL_PERIOD_US = 125;
  localparam int CTRL_TICK_CYCLES = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
  localparam int TICKS_PER_S = 1_000_000 / CTRL_PERIOD_US;
  localparam int HOMING_TIMEOUT_MS = 10000;
  localparam int HOMING_TIMEOUT_TICKS =
    HOMING_TIMEOUT_MS * (TICKS_PER_S / 1000);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_HOMING = 2'h0,
    MODE_CSP = 2'h1,
    MODE_CSV = 2'h2,
    MODE_CST = 2'h3
  } hao_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } hao_obj_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } hao_obj_rsp_t;

  typedef struct packed {
    logic [31:0] sw_speed;
    logic [31:0] zero_speed;
    logic [31:0] acc;
    logic [31:0] pos_off;
    logic [31:0] vel_off;
    logic [15:0] trq_off;
    logic [15:0] probe_fn;
  } hao_objs_t;

  typedef struct packed {
    logic neg_edge;
    logic pos_edge;
    logic src_index;
    logic continuous;
    logic enable;
  } hao_probe_cfg_t;

  // speed change per control tick for a given acceleration
  function automatic logic [31:0] hao_ramp_step(input logic [31:0] acc);
    logic [31:0] q;
    q = acc / 32'(TICKS_PER_S);
    return (q == 32'h0) ? 32'h1 : q;
  endfunction

  function automatic hao_probe_cfg_t hao_probe_cfg(input logic [5:0] f);
    hao_probe_cfg_t c;
    c.enable = f[PRB_EN];
    c.continuous = f[PRB_CONT];
    c.src_index = f[PRB_SRC];
    c.pos_edge = f[PRB_POS];
    c.neg_edge = f[PRB_NEG];
    return c;
  endfunction

endpackage

//--- core/hao_ref_sum.sv
// Purpose: offsets and feedforward applied to cyclic references
// Assumes: commanded references valid in the cycle they are sampled
// Notes: one cycle of latency on every output
`timescale 1ns/100ps
module hao_ref_sum (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire hao_pkg::hao_mode_t mode_in,
  input wire hao_pkg::hao_objs_t objs_in,
  input wire logic [31:0] commanded_target_position_in,
  input wire logic [31:0] speed_ref_in,
  input wire logic [15:0] commanded_target_torque_in,
  input wire logic [15:0] speed_feedforward_source_setting_in,
  input wire logic [15:0] torque_feedforward_source_setting_in,
  output logic [31:0] eff_target_position_out,
  output logic [31:0] eff_speed_ref_out,
  output logic [31:0] speed_ff_out,
  output logic [15:0] torque_ff_out,
  output logic [15:0] eff_target_torque_out
);
  logic [31:0] pos_nxt;
  logic [31:0] spd_nxt;
  logic [31:0] sff_nxt;
  logic [15:0] tff_nxt;
  logic [15:0] trq_nxt;
  logic signed [16:0] trq_sum;

  always_comb
  begin
    trq_sum = 17'($signed(commanded_target_torque_in))
      + 17'($signed(objs_in.trq_off));
    pos_nxt = commanded_target_position_in;
    spd_nxt = speed_ref_in;
    sff_nxt = 32'h0;
    tff_nxt = 16'h0;
    trq_nxt = commanded_target_torque_in;
    if (mode_in == hao_pkg::MODE_CSP)
    begin
      pos_nxt = commanded_target_position_in + objs_in.pos_off;
      if (speed_feedforward_source_setting_in == hao_pkg::FF_SRC_EXTERNAL)
        sff_nxt = objs_in.vel_off;
    end
    if (mode_in == hao_pkg::MODE_CSV)
      spd_nxt = speed_ref_in + objs_in.vel_off;
    if ((mode_in == hao_pkg::MODE_CSP || mode_in == hao_pkg::MODE_CSV) &&
        torque_feedforward_source_setting_in == hao_pkg::FF_SRC_EXTERNAL)
      tff_nxt = objs_in.trq_off;
    if (mode_in == hao_pkg::MODE_CST)
    begin
      // saturate rather than wrap the torque reference
      if (trq_sum > 17'(hao_pkg::TRQ_SAT_MAX))
        trq_nxt = hao_pkg::TRQ_SAT_MAX;
      else if (trq_sum < 17'(hao_pkg::TRQ_SAT_MIN))
        trq_nxt = hao_pkg::TRQ_SAT_MIN;
      else
        trq_nxt = trq_sum[15:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      eff_target_position_out <= 32'h0;
      eff_speed_ref_out <= 32'h0;
      speed_ff_out <= 32'h0;
      torque_ff_out <= 16'h0;
      eff_target_torque_out <= 16'h0;
    end
    else
    begin
      eff_target_position_out <= pos_nxt;
      eff_speed_ref_out <= spd_nxt;
      speed_ff_out <= sff_nxt;
      torque_ff_out <= tff_nxt;
      eff_target_torque_out <= trq_nxt;
    end
  end
endmodule

//--- core/hao_tick.sv
// Purpose: control-cycle enable divider
// Assumes: PERIOD of at least 2 clock cycles
// Notes: tick is a one-cycle pulse
`timescale 1ns/100ps
module hao_tick #(
  parameter int PERIOD = hao_pkg::CTRL_TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic tick_nxt;

  always_comb
  begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 32'h1;
    if (cnt_r == 32'(PERIOD - 1))
    begin
      cnt_nxt = 32'h0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_r <= 32'h0;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_out <= tick_nxt;
    end
  end
endmodule

//--- verification/hao_homing_objects_sva.sv
// Purpose: port-level checks of the homing and offset objects
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound to the top module from the bench top file
`timescale 1ns/100ps
module hao_homing_objects_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire hao_pkg::hao_obj_req_t obj_req_in,
  input wire hao_pkg::hao_obj_rsp_t obj_rsp_out,
  input wire hao_pkg::hao_mode_t mode_in,
  input wire logic homing_start_in,
  input wire logic halt_in,
  input wire logic home_signal_in,
  input wire logic [15:0] speed_feedforward_source_setting_in,
  input wire logic [15:0] torque_feedforward_source_setting_in,
  input wire logic [31:0] homing_speed_out,
  input wire logic homing_busy_out,
  input wire logic homing_done_out,
  input wire logic homing_timeout_fault_out,
  input wire logic home_blocked_out,
  input wire logic [31:0] speed_ff_out,
  input wire logic [15:0] torque_ff_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff rst_in;

  a_ack_follows: assert property (
    (obj_req_in.wr || obj_req_in.rd) |=> obj_rsp_out.ack)
    else $error("no ack after request");
  a_no_stray_ack: assert property (
    !(obj_req_in.wr || obj_req_in.rd) |=> !obj_rsp_out.ack)
    else $error("ack without request");
  a_count_read_only: assert property (
    obj_req_in.wr && obj_req_in.index == 16'h6099 &&
    obj_req_in.sub == 8'h00 |=> obj_rsp_out.err)
    else $error("entry count write not refused");
  a_zero_speed_min: assert property (
    obj_req_in.wr && obj_req_in.index == 16'h6099 &&
    obj_req_in.sub == 8'h02 && obj_req_in.wdata < 32'h0000000A
    |=> obj_rsp_out.ack && obj_rsp_out.err)
    else $error("low zero-search speed accepted");
  a_start_busy: assert property (
    homing_start_in && mode_in == hao_pkg::MODE_HOMING &&
    !homing_busy_out && !halt_in |=> homing_busy_out)
    else $error("homing start not taken");
  a_blocked_home: assert property (
    home_blocked_out && $rose(home_signal_in) |=> !homing_done_out)
    else $error("home edge seen while decelerating");
  a_speed_ff_gate: assert property (
    speed_feedforward_source_setting_in != 16'h0002 ||
    mode_in != hao_pkg::MODE_CSP |=> speed_ff_out == 32'h0)
    else $error("speed feedforward without source");
  a_torque_ff_gate: assert property (
    torque_feedforward_source_setting_in != 16'h0002 ||
    mode_in == hao_pkg::MODE_CST || mode_in == hao_pkg::MODE_HOMING
    |=> torque_ff_out == 16'h0000)
    else $error("torque feedforward without source");
  a_fault_stops: assert property (
    $rose(homing_timeout_fault_out) |-> homing_speed_out == 32'h0)
    else $error("speed not zero on homing timeout");
endmodule

//--- verification/hao_homing_objects_tb.sv
// Purpose: self-checking bench of the homing and offset objects
// Assumes: shortened tick of 4 cycles and timeout of 50 ticks
// Notes: expected values are worked out by hand from the objects
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
`define WT(c) \
  for (k = 0; k < 400 && !(c); k++) @(posedge clk_in); \
  if (k >= 400) n_mismatch++; \
  #1;
module hao_homing_objects_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  hao_pkg::hao_obj_req_t req;
  hao_pkg::hao_obj_rsp_t rsp;
  hao_pkg::hao_mode_t mode = hao_pkg::MODE_HOMING;
  logic start = 1'b0;
  logic halt = 1'b0;
  logic decel = 1'b0;
  logic home = 1'b0;
  logic [15:0] stop_opt = 16'h0;
  logic [31:0] cpos = 32'h100;
  logic [31:0] sref = 32'h40;
  logic [15:0] ctrq = 16'h64;
  logic [15:0] sfs = 16'h2;
  logic [15:0] tfs = 16'h2;
  logic [31:0] hspd, hacc, epos, esref, sff, rdv;
  logic [15:0] tff, etrq;
  logic busy, done, fault, blk, erv;
  hao_pkg::hao_probe_cfg_t p1, p2;
  int compares = 0;
  int n_mismatch = 0;
  int k;
  logic [15:0] t_idx [8] = '{16'h6099, 16'h6099, 16'h6099, 16'h609A,
    16'h60B0, 16'h60B1, 16'h60B2, 16'h60B8};
  logic [7:0] t_sub [8] = '{8'h0, 8'h1, 8'h2, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
  logic [31:0] t_rst [8] = '{32'h2, 32'h1AAAAB, 32'h64, 32'h64,
    32'h0, 32'h0, 32'h0, 32'h0};

  always #2.5 clk_in = ~clk_in;

  hao_host_model host (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));

  hao_homing_objects #(.TICK_CYCLES(4), .TIMEOUT_TICKS(50)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .obj_req_in(req), .obj_rsp_out(rsp),
    .mode_in(mode), .homing_start_in(start), .halt_in(halt),
    .stop_option_setting_in(stop_opt), .decel_point_in(decel),
    .home_signal_in(home), .commanded_target_position_in(cpos),
    .speed_ref_in(sref), .commanded_target_torque_in(ctrq),
    .speed_feedforward_source_setting_in(sfs),
    .torque_feedforward_source_setting_in(tfs),
    .homing_speed_out(hspd), .homing_accel_out(hacc),
    .homing_busy_out(busy), .homing_done_out(done),
    .homing_timeout_fault_out(fault), .home_blocked_out(blk),
    .probe1_cfg_out(p1), .probe2_cfg_out(p2),
    .eff_target_position_out(epos), .eff_speed_ref_out(esref),
    .speed_ff_out(sff), .torque_ff_out(tff), .eff_target_torque_out(etrq));

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rd_chk(input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] e);
    host.xfer(1'b0, i, s, 32'h0, rdv, erv);
    `CHK("read err", 1'b0, erv)
    `CHK("read data", e, rdv)
  endtask

  task automatic wr_chk(input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, input logic e);
    host.xfer(1'b1, i, s, d, rdv, erv);
    `CHK("write err", e, erv)
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  task automatic pulse_start;
    @(posedge clk_in);
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    #1;
  endtask

  // whole run is well under 2000 cycles
  initial
  begin
    #50000;
    n_mismatch++;
    give_verdict;
  end

  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    for (k = 0; k < 8; k++)
      rd_chk(t_idx[k], t_sub[k], t_rst[k]);
    host.xfer(1'b0, 16'h1234, 8'h00, 32'h0, rdv, erv);
    `CHK("unmapped", 1'b1, erv)
    wr_chk(16'h6099, 8'h00, 32'h5, 1'b1);
    rd_chk(16'h6099, 8'h00, 32'h2);
    wr_chk(16'h6099, 8'h02, 32'h9, 1'b1);
    wr_chk(16'h6099, 8'h02, 32'hA, 1'b0);
    wr_chk(16'h609A, 8'h00, 32'h0, 1'b0);
    rd_chk(16'h609A, 8'h00, 32'h1);
    wr_chk(16'h60B2, 8'h00, 32'hBB9, 1'b1);
    wr_chk(16'h60B2, 8'h00, 32'hFFFFF448, 1'b0);
    rd_chk(16'h60B2, 8'h00, 32'hFFFFF448);
    wr_chk(16'h60B8, 8'h00, 32'h1532, 1'b0);
    settle;
    `CHK("probe1", 5'h1A, p1)
    `CHK("probe2", 5'h0D, p2)
    wr_chk(16'h60B0, 8'h00, 32'h10, 1'b0);
    wr_chk(16'h60B1, 8'h00, 32'h5, 1'b0);
    mode <= hao_pkg::MODE_CSP;
    settle;
    `CHK("eff pos", 32'h110, epos)
    `CHK("speed ff", 32'h5, sff)
    `CHK("trq ff csp", 16'hF448, tff)
    sfs <= 16'h1;
    mode <= hao_pkg::MODE_CSV;
    settle;
    `CHK("speed ff off", 32'h0, sff)
    `CHK("eff speed", 32'h45, esref)
    `CHK("trq ff csv", 16'hF448, tff)
    wr_chk(16'h60B1, 8'h00, 32'h0, 1'b0);
    settle;
    `CHK("speed cleared", 32'h40, esref)
    mode <= hao_pkg::MODE_CST;
    settle;
    `CHK("eff trq", 16'(16'h64 + 16'hF448), etrq)
    mode <= hao_pkg::MODE_HOMING;
    wr_chk(16'h6099, 8'h01, 32'h14, 1'b0);
    wr_chk(16'h609A, 8'h00, 32'h3E80, 1'b0);
    pulse_start;
    `CHK("busy", 1'b1, busy)
    `CHK("switch speed", 32'h14, hspd)
    wr_chk(16'h609A, 8'h00, 32'h13880, 1'b0);
    `CHK("acc held", 32'h3E80, hacc)
    decel <= 1'b1;
    settle;
    `CHK("blocked", 1'b1, blk)
    home <= 1'b1;
    settle;
    home <= 1'b0;
    `CHK("home ignored", 1'b0, done)
    `WT(!blk)
    `CHK("zero speed", 32'hA, hspd)
    home <= 1'b1;
    settle;
    `CHK("done", 1'b1, done)
    `CHK("idle speed", 32'h0, hspd)
    home <= 1'b0;
    decel <= 1'b0;
    stop_opt <= 16'h2;
    pulse_start;
    `CHK("acc latched", 32'h13880, hacc)
    halt <= 1'b1;
    `WT(hspd !== 32'h14)
    `CHK("ramp step", 32'hA, hspd)
    `WT(!busy)
    `CHK("stopped", 32'h0, hspd)
    halt <= 1'b0;
    stop_opt <= 16'h0;
    pulse_start;
    `WT(fault)
    `CHK("timeout", 1'b1, fault)
    `CHK("fault speed", 32'h0, hspd)
    give_verdict;
  end
endmodule

bind hao_homing_objects hao_homing_objects_sva chk (
  .clk_in(clk_in), .rst_in(rst_in), .obj_req_in(obj_req_in),
  .obj_rsp_out(obj_rsp_out), .mode_in(mode_in),
  .homing_start_in(homing_start_in), .halt_in(halt_in),
  .home_signal_in(home_signal_in),
  .speed_feedforward_source_setting_in(speed_feedforward_source_setting_in),
  .torque_feedforward_source_setting_in(
    torque_feedforward_source_setting_in),
  .homing_speed_out(homing_speed_out), .homing_busy_out(homing_busy_out),
  .homing_done_out(homing_done_out),
  .homing_timeout_fault_out(homing_timeout_fault_out),
  .home_blocked_out(home_blocked_out), .speed_ff_out(speed_ff_out),
  .torque_ff_out(torque_ff_out));

//--- verification/hao_host_model.sv
// Purpose: host side of the object access port
// Assumes: requests are one cycle, answer one cycle later
// Notes: idle strobes are low; index, sub and data lines show the inverse of the last request
`timescale 1ns/100ps
module hao_host_model (
  input wire logic clk_in,
  input wire hao_pkg::hao_obj_rsp_t rsp_in,
  output hao_pkg::hao_obj_req_t req_out
);
  initial req_out = '0;

  // strobe drops after one edge; a held strobe would be taken twice
  task automatic xfer(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    req_out <= '{wr, ~wr, idx, sub, wd};
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b0, ~idx, ~sub, ~wd};
    @(posedge clk_in);
    rd = rsp_in.rdata;
    // a missing ack leaves err unknown so any compare fails
    err = rsp_in.ack ? rsp_in.err : 1'bx;
  endtask
endmodule
